// ===== hw/tlbt_pkg.sv
// package for the translation cache test port: offsets, field layout, sizes
package tlbt_pkg;
  localparam logic [7:0] TLBT_OFS_CMD = 8'h00;
  localparam logic [7:0] TLBT_OFS_DATA = 8'h04;
  localparam logic [7:0] TLBT_OFS_PTBASE = 8'h08;
  localparam logic [7:0] TLBT_OFS_MCTRL = 8'h0C;
  // command register fields
  localparam int TLBT_CMD_BIT = 0;
  localparam int TLBT_W_NEG = 5;
  localparam int TLBT_W_POS = 6;
  localparam int TLBT_U_NEG = 7;
  localparam int TLBT_U_POS = 8;
  localparam int TLBT_D_NEG = 9;
  localparam int TLBT_D_POS = 10;
  localparam int TLBT_V_BIT = 11;
  localparam int TLBT_LA_LSB = 12;
  // data register fields
  localparam int TLBT_WAY_LSB = 2;
  localparam int TLBT_HIT_BIT = 4;
  localparam int TLBT_PA_LSB = 12;
  // machine control: translation enable in bit 31
  localparam int TLBT_PAGING_BIT = 31;
  localparam int TLBT_TAG_W = 20;
  localparam int TLBT_WAY_W = 2;
  localparam int TLBT_WAYS = 4;
  localparam int TLBT_SETS = 8;
  localparam int TLBT_SET_W = 3;
  localparam logic [31:0] TLBT_ZERO = 32'h0000_0000;
  localparam logic [1:0] TLBT_PAIR_ZERO = 2'h1;
  localparam logic [1:0] TLBT_PAIR_ONE = 2'h2;
endpackage

// ===== hw/tlbt_test_port.sv
// translation cache test port with apb register access
// What this block does
// - command write starts write or lookup
// - write allocates entry tagged by linear address
// - single match loads test register fields
// - physical address stored, or returned on hit
// - pin flag selects way, else pointer
// - lookup sets flag on hit, clears on miss
// - page table base write clears all valid
// - attribute pairs match zero, one, any, none
// - fields undefined after a miss
`timescale 1ns/1ps
module tlbt_test_port
  import tlbt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic paging_on
);
  typedef struct packed {
    logic v;
    logic d;
    logic u;
    logic w;
    logic [TLBT_TAG_W-1:0] tag;
    logic [TLBT_TAG_W-1:0] pa;
  } tlbt_entry_t;

  typedef struct packed {
    logic [31:0] cmd_reg;
    logic [31:0] data_reg;
    logic [31:0] ptbase_reg;
    logic [31:0] mctrl_reg;
    logic [TLBT_WAY_W-1:0] way_pick_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic paging_reg;
  } tlbt_state_t;

  tlbt_state_t st_reg;
  tlbt_state_t st_next;
  tlbt_entry_t mem_reg [TLBT_WAYS][TLBT_SETS];
  logic [TLBT_WAYS-1:0] match;
  logic [TLBT_WAY_W-1:0] hit_way;
  logic one_hit;
  logic acc;
  logic cmd_wr;
  logic [31:0] wval;
  logic [TLBT_SET_W-1:0] wset;
  logic [TLBT_WAY_W-1:0] wway;
  tlbt_entry_t wentry;
  logic [TLBT_TAG_W-1:0] hit_pa;
  logic [TLBT_TAG_W-1:0] data_pa;
  logic [TLBT_WAY_W-1:0] data_way;
  logic [TLBT_WAY_W-1:0] pick_cur;
  logic mctrl_pg;
  logic any_valid;

  // pointer step sized to the pointer so the wrap from the last way is explicit
  localparam logic [TLBT_WAY_W-1:0] TLBT_WAY_STEP = TLBT_WAY_W'(1);

  // pair matching: x,x# of 0,0 never matches, 1,1 always
  function automatic logic tlbt_pair_ok(input logic pos, input logic neg, input logic val);
    tlbt_pair_ok = (pos & val) | (neg & ~val);
  endfunction

  // stored value for a pair; undefined pairs keep the positive bit
  function automatic logic tlbt_pair_val(input logic pos, input logic neg);
    tlbt_pair_val = ({pos, neg} == TLBT_PAIR_ONE) ? 1'b1 : 1'b0;
    if ({pos, neg} != TLBT_PAIR_ONE && {pos, neg} != TLBT_PAIR_ZERO)
    begin
      tlbt_pair_val = pos;
    end
  endfunction

  assign acc = psel & penable & ~st_reg.pready_reg;
  assign cmd_wr = acc & pwrite & (paddr == TLBT_OFS_CMD);
  assign wval = pwdata;
  assign wset = wval[TLBT_LA_LSB +: TLBT_SET_W];

  genvar gw;
  generate
    for (gw = 0; gw < TLBT_WAYS; gw++)
    begin : g_cmp
      tlbt_entry_t e;
      assign e = mem_reg[gw][wset];
      assign match[gw] = e.v && (e.tag == wval[TLBT_LA_LSB +: TLBT_TAG_W])
        && tlbt_pair_ok(wval[TLBT_D_POS], wval[TLBT_D_NEG], e.d)
        && tlbt_pair_ok(wval[TLBT_U_POS], wval[TLBT_U_NEG], e.u)
        && tlbt_pair_ok(wval[TLBT_W_POS], wval[TLBT_W_NEG], e.w);
    end
  endgenerate

  always_comb
  begin
    hit_way = '0;
    for (int i = 0; i < TLBT_WAYS; i++)
    begin
      if (match[i])
      begin
        hit_way = i[TLBT_WAY_W-1:0];
      end
    end
    one_hit = $onehot(match);
  end

  // placement: pinned way or internal pointer
  assign wway = st_reg.data_reg[TLBT_HIT_BIT] ? st_reg.data_reg[TLBT_WAY_LSB +: TLBT_WAY_W]
    : st_reg.way_pick_reg;

  always_comb
  begin
    wentry.v = wval[TLBT_V_BIT];
    wentry.d = tlbt_pair_val(wval[TLBT_D_POS], wval[TLBT_D_NEG]);
    wentry.u = tlbt_pair_val(wval[TLBT_U_POS], wval[TLBT_U_NEG]);
    wentry.w = tlbt_pair_val(wval[TLBT_W_POS], wval[TLBT_W_NEG]);
    wentry.tag = wval[TLBT_LA_LSB +: TLBT_TAG_W];
    wentry.pa = st_reg.data_reg[TLBT_PA_LSB +: TLBT_TAG_W];
  end

  always_comb
  begin
    tlbt_entry_t he;
    he = mem_reg[hit_way][wset];
    st_next = st_reg;
    st_next.pready_reg = acc;
    st_next.pslverr_reg = 1'b0;
    st_next.paging_reg = st_reg.mctrl_reg[TLBT_PAGING_BIT];
    if (acc)
    begin
      if (pwrite)
      begin
        case (paddr)
          TLBT_OFS_CMD:
          begin
            st_next.cmd_reg = wval;
            if (wval[TLBT_CMD_BIT])
            begin
              // lookup; on a miss other fields keep stale values
              st_next.data_reg[TLBT_HIT_BIT] = one_hit;
              if (one_hit)
              begin
                st_next.data_reg[TLBT_PA_LSB +: TLBT_TAG_W] = he.pa;
                st_next.data_reg[TLBT_WAY_LSB +: TLBT_WAY_W] = hit_way;
                st_next.cmd_reg[TLBT_V_BIT] = he.v;
                st_next.cmd_reg[TLBT_D_POS] = he.d;
                st_next.cmd_reg[TLBT_D_NEG] = ~he.d;
                st_next.cmd_reg[TLBT_U_POS] = he.u;
                st_next.cmd_reg[TLBT_U_NEG] = ~he.u;
                st_next.cmd_reg[TLBT_W_POS] = he.w;
                st_next.cmd_reg[TLBT_W_NEG] = ~he.w;
              end
            end
            else if (!st_reg.data_reg[TLBT_HIT_BIT])
            begin
              st_next.way_pick_reg = st_reg.way_pick_reg + TLBT_WAY_STEP;
            end
          end
          TLBT_OFS_DATA: st_next.data_reg = wval;
          TLBT_OFS_PTBASE: st_next.ptbase_reg = wval;
          TLBT_OFS_MCTRL: st_next.mctrl_reg = wval;
          default: st_next.pslverr_reg = 1'b1;
        endcase
      end
      else
      begin
        case (paddr)
          TLBT_OFS_CMD: st_next.prdata_reg = st_reg.cmd_reg;
          TLBT_OFS_DATA: st_next.prdata_reg = st_reg.data_reg;
          TLBT_OFS_PTBASE: st_next.prdata_reg = st_reg.ptbase_reg;
          TLBT_OFS_MCTRL: st_next.prdata_reg = st_reg.mctrl_reg;
          default:
          begin
            st_next.prdata_reg = TLBT_ZERO;
            st_next.pslverr_reg = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // entry array kept out of the state struct so it maps to plain storage
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || (acc && pwrite && paddr == TLBT_OFS_PTBASE))
    begin
      for (int a = 0; a < TLBT_WAYS; a++)
      begin
        for (int b = 0; b < TLBT_SETS; b++)
        begin
          mem_reg[a][b].v <= 1'b0;
        end
      end
    end
    else if (cmd_wr && !wval[TLBT_CMD_BIT])
    begin
      mem_reg[wway][wset] <= wentry;
    end
  end

  assign prdata = st_reg.prdata_reg;
  assign pready = st_reg.pready_reg;
  assign pslverr = st_reg.pslverr_reg;
  // exported so the core can confirm translation is off while testing
  assign paging_on = st_reg.paging_reg;

  // observation taps for the checks below
  assign hit_pa = mem_reg[hit_way][wset].pa;
  assign data_pa = st_reg.data_reg[TLBT_PA_LSB +: TLBT_TAG_W];
  assign data_way = st_reg.data_reg[TLBT_WAY_LSB +: TLBT_WAY_W];
  assign pick_cur = st_reg.way_pick_reg;
  assign mctrl_pg = st_reg.mctrl_reg[TLBT_PAGING_BIT];

  // sweeps every entry, so a partial invalidate cannot slip past the check
  always_comb
  begin
    any_valid = 1'b0;
    for (int a = 0; a < TLBT_WAYS; a++)
    begin
      for (int b = 0; b < TLBT_SETS; b++)
      begin
        any_valid = any_valid | mem_reg[a][b].v;
      end
    end
  end

  // all checks look one cycle after the edge that triggers them, where the registers have settled
  AST_PREADY_ONE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (psel && penable && !pready) |=> pready)
    else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_CMD_STORE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && !wval[TLBT_CMD_BIT]) |=> st_reg.cmd_reg == $past(wval))
    else $error("command value not stored");
  AST_HIT_FLAG: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wval[TLBT_CMD_BIT]) |=> st_reg.data_reg[TLBT_HIT_BIT] == $past(one_hit))
    else $error("hit flag wrong after lookup");
  AST_MULTI_MISS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wval[TLBT_CMD_BIT] && !$onehot0(match)) |=> !st_reg.data_reg[TLBT_HIT_BIT])
    else $error("multiple match not reported as miss");
  AST_HIT_PA: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wval[TLBT_CMD_BIT] && one_hit) |=> data_pa == $past(hit_pa))
    else $error("physical address not returned on hit");
  AST_HIT_WAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wval[TLBT_CMD_BIT] && one_hit) |=> data_way == $past(hit_way))
    else $error("matching way not returned on hit");
  AST_MISS_KEEPS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && wval[TLBT_CMD_BIT] && !one_hit) |=> $stable(data_pa))
    else $error("physical address field moved on a miss");
  AST_INVALIDATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (acc && pwrite && paddr == TLBT_OFS_PTBASE) |=> !any_valid)
    else $error("valid bits not cleared");
  AST_PIN_WAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && !wval[TLBT_CMD_BIT] && st_reg.data_reg[TLBT_HIT_BIT]) |=>
    $stable(pick_cur))
    else $error("pointer moved on pinned write");
  AST_PICK_STEP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmd_wr && !wval[TLBT_CMD_BIT] && !st_reg.data_reg[TLBT_HIT_BIT]) |=>
    pick_cur == $past(pick_cur) + TLBT_WAY_STEP)
    else $error("pointer did not advance on unpinned write");
  AST_PAGING_COPY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1 |=> paging_on == $past(mctrl_pg))
    else $error("paging_on does not follow the control bit");
  AST_UNMAPPED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (acc && paddr > TLBT_OFS_MCTRL) |=> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_UNMAPPED_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (acc && !pwrite && paddr > TLBT_OFS_MCTRL) |=> prdata == TLBT_ZERO)
    else $error("unmapped read not zero");
  AST_MAPPED_OK: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (acc && (paddr == TLBT_OFS_CMD || paddr == TLBT_OFS_DATA || paddr == TLBT_OFS_PTBASE
    || paddr == TLBT_OFS_MCTRL)) |=> !pslverr && pready)
    else $error("mapped access flagged as error");
endmodule

// ===== dv/tlbt_testbench.sv
// self-checking bench for the translation cache test port
`timescale 1ns/1ps
module testbench
  import tlbt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic paging_on;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  tlbt_test_port tlbt_test_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .paging_on(paging_on));

  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    checks++;
    if ((got & mask) !== (exp & mask))
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered and left right after a rising edge
  task xfer(input logic wr_en, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: no pready", $time);
      stop_test();
    end
    // idle cycle keeps a driver from assigning psel twice in one step
    @(posedge sys_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    xfer(1'b0, a, TLBT_ZERO);
    check(rd, exp, mask);
    check({31'h0, err}, TLBT_ZERO, 32'h0000_0001);
  endtask

  function automatic logic [31:0] cmdw(input logic [19:0] la, input logic [5:0] pr, input logic c);
    return {la, 1'b1, pr, 4'h0, c};
  endfunction

  function automatic logic [31:0] datw(input logic [19:0] pa, input logic pin, input logic [1:0] way);
    return {pa, 7'h00, pin, way, 2'h0};
  endfunction

  // every entry is written with dirty 1, user 0, writable 1
  task put(input logic [19:0] la, input logic [19:0] pa, input logic pin, input logic [1:0] way);
    wr(TLBT_OFS_DATA, datw(pa, pin, way));
    wr(TLBT_OFS_CMD, cmdw(la, 6'h26, 1'b0));
  endtask

  // fields other than the flag are only compared on a hit
  task look(input logic [19:0] la, input logic [5:0] pr, input logic hit, input logic [19:0] pa,
    input logic [1:0] way);
    wr(TLBT_OFS_CMD, cmdw(la, pr, 1'b1));
    rdc(TLBT_OFS_DATA, datw(pa, hit, way), hit ? 32'hFFFF_F01C : 32'h0000_0010);
    if (hit)
      rdc(TLBT_OFS_CMD, cmdw(la, 6'h26, 1'b1), 32'hFFFF_FFE0);
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++)
      rdc(8'(i * 4), TLBT_ZERO, 32'hFFFF_FFFF);
    wr(8'h10, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b0, 8'h10, TLBT_ZERO);
    check(rd, TLBT_ZERO, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001, 32'h0000_0001);
    put(20'h12345, 20'hABCDE, 1'b0, 2'h3);
    look(20'h12345, 6'h3F, 1'b1, 20'hABCDE, 2'h0);
    put(20'h22345, 20'h2468A, 1'b0, 2'h3);
    look(20'h22345, 6'h3F, 1'b1, 20'h2468A, 2'h1);
    look(20'h12345, 6'h3F, 1'b1, 20'hABCDE, 2'h0);
    put(20'h32345, 20'h13579, 1'b1, 2'h3);
    look(20'h32345, 6'h3F, 1'b1, 20'h13579, 2'h3);
    look(20'h52345, 6'h3F, 1'b0, 20'h00000, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      look(20'h12345, {4'hF, 2'(i)}, i[1], 20'hABCDE, 2'h0);
      look(20'h12345, {2'h3, 2'(i), 2'h3}, i[0], 20'hABCDE, 2'h0);
      look(20'h12345, {2'(i), 4'hF}, i[1], 20'hABCDE, 2'h0);
    end
    put(20'h42345, 20'h11111, 1'b1, 2'h1);
    put(20'h42345, 20'h22222, 1'b1, 2'h2);
    look(20'h42345, 6'h3F, 1'b0, 20'h00000, 2'h0);
    wr(TLBT_OFS_MCTRL, 32'h8000_0000);
    check({31'h0, paging_on}, 32'h0000_0001, 32'h0000_0001);
    wr(TLBT_OFS_MCTRL, TLBT_ZERO);
    check({31'h0, paging_on}, TLBT_ZERO, 32'h0000_0001);
    wr(TLBT_OFS_PTBASE, 32'h0000_1000);
    look(20'h12345, 6'h3F, 1'b0, 20'h00000, 2'h0);
    look(20'h32345, 6'h3F, 1'b0, 20'h00000, 2'h0);
    stop_test();
  end
endmodule
